// >>> design/pci_command_status_bits.sv
// Command and status bits of the PCI configuration header with their bus-side effects.
`include "pci_cmd_status_consts.svh"
module pci_command_status_bits (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             rd_i,
  input  wire logic                             wr_i,
  input  wire logic [15:0]                      addr_i,
  input  wire pci_cmd_status_pkg::byte_en_type  be_i,
  input  wire pci_cmd_status_pkg::word_type     wdata_i,
  input  wire logic                             satellite_mode_i,
  input  wire logic                             strap_pci_boot_i,
  input  wire logic                             strap_host_mode_i,
  input  wire logic                             perr_seen_i,
  input  wire logic                             master_of_failing_i,
  input  wire logic                             data_parity_err_i,
  input  wire logic                             addr_parity_err_i,
  input  wire logic                             special_parity_err_i,
  input  wire logic                             mem_access_i,
  input  wire logic                             io_access_i,
  input  wire logic                             special_cycle_i,
  output pci_cmd_status_pkg::word_type          rdata_o,
  output logic                                  ack_o,
  output logic                                  err_o,
  output logic                                  perr_assert_o,
  output logic                                  serr_assert_o,
  output logic                                  parity_check_o,
  output logic                                  fast_b2b_issue_o,
  output pci_cmd_status_pkg::pci_cmd_type       write_cmd_o,
  output logic                                  bus_master_allow_o,
  output logic                                  mem_claim_o,
  output logic                                  io_claim_o,
  output logic                                  special_claim_o
);

  // Register bus decode.
  logic                            addr_hit;
  logic                            access_ok;
  logic                            rd_hit;
  logic                            wr_hit;
  logic                            wr_byte0;
  logic                            wr_byte1;
  logic                            wr_byte3;
  logic                            access_any;
  pci_cmd_status_pkg::word_type    read_value;
  pci_cmd_status_pkg::word_type    rdata_d;
  pci_cmd_status_pkg::pci_cmd_type write_cmd_d;

  // Field state.
  logic master_data_parity_flag;
  logic fast_b2b_enable;
  logic system_error_enable;
  logic parity_response_enable;
  logic write_invalidate_enable;
  logic bus_master_enable;
  logic memory_space_enable;
  logic io_space_enable;
  logic strap_loaded_q;
  logic strap_load;
  logic strap_value;
  logic parity_flag_set;
  logic parity_flag_clear;
  logic serr_d;
  logic perr_d;
  logic ack_q;
  logic err_q;

  assign addr_hit   = (addr_i == `CSR_OFFSET);
  assign access_any = (rd_i | wr_i) & addr_hit;
  assign access_ok  = addr_hit & ~satellite_mode_i;
  assign rd_hit     = rd_i & access_ok;
  assign wr_hit     = wr_i & access_ok;
  assign wr_byte0   = wr_hit & be_i[0];
  assign wr_byte1   = wr_hit & be_i[1];
  assign wr_byte3   = wr_hit & be_i[3];

  // Straps are taken on the first edge after reset release, never by the reset itself.
  assign strap_load  = ~strap_loaded_q;
  assign strap_value = strap_pci_boot_i & strap_host_mode_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_loaded_q <= 1'h0;
    end else begin
      strap_loaded_q <= 1'h1;
    end
  end

  // Acting as target never reaches this flag; the master qualifier filters it.
  assign parity_flag_set   = perr_seen_i & master_of_failing_i & parity_response_enable;
  assign parity_flag_clear = wr_byte3 & wdata_i[`BIT_MASTER_PARITY];

  sticky_flag u_master_parity (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (parity_flag_set),
    .clear_i (parity_flag_clear),
    .flag_o  (master_data_parity_flag)
  );

  control_field #(.WIDTH(1)) u_fast_b2b (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte1),
    .wdata_i      (wdata_i[`BIT_FAST_B2B_ENABLE]),
    .load_i       (1'h0),
    .load_value_i (`RESET_CONTROL),
    .value_o      (fast_b2b_enable)
  );

  control_field #(.WIDTH(1)) u_system_error (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte1),
    .wdata_i      (wdata_i[`BIT_SYSTEM_ERROR_EN]),
    .load_i       (1'h0),
    .load_value_i (`RESET_CONTROL),
    .value_o      (system_error_enable)
  );

  control_field #(.WIDTH(1)) u_parity_response (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte0),
    .wdata_i      (wdata_i[`BIT_PARITY_RESPONSE]),
    .load_i       (1'h0),
    .load_value_i (`RESET_CONTROL),
    .value_o      (parity_response_enable)
  );

  control_field #(.WIDTH(1)) u_write_invalidate (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte0),
    .wdata_i      (wdata_i[`BIT_WRITE_INVALIDATE]),
    .load_i       (1'h0),
    .load_value_i (`RESET_CONTROL),
    .value_o      (write_invalidate_enable)
  );

  // The strap load beats a write in the same cycle.
  control_field #(.WIDTH(1)) u_bus_master (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte0),
    .wdata_i      (wdata_i[`BIT_BUS_MASTER]),
    .load_i       (strap_load),
    .load_value_i (strap_value),
    .value_o      (bus_master_enable)
  );

  control_field #(.WIDTH(1)) u_memory_space (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte0),
    .wdata_i      (wdata_i[`BIT_MEMORY_SPACE]),
    .load_i       (1'h0),
    .load_value_i (`RESET_CONTROL),
    .value_o      (memory_space_enable)
  );

  control_field #(.WIDTH(1)) u_io_space (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_byte0),
    .wdata_i      (wdata_i[`BIT_IO_SPACE]),
    .load_i       (1'h0),
    .load_value_i (`RESET_CONTROL),
    .value_o      (io_space_enable)
  );

  // Read image; every position not named below stays zero.
  always_comb begin
    read_value = `RESET_WORD;
    read_value[`BIT_MASTER_PARITY]      = master_data_parity_flag;
    read_value[`BIT_FAST_B2B_CAPABLE]   = `FIXED_ONE;
    read_value[`BIT_HIGH_SPEED_CAPABLE] = `FIXED_ONE;
    read_value[`BIT_CAPABILITIES_LIST]  = `FIXED_ONE;
    read_value[`BIT_FAST_B2B_ENABLE]    = fast_b2b_enable;
    read_value[`BIT_SYSTEM_ERROR_EN]    = system_error_enable;
    read_value[`BIT_STEPPING_CONTROL]   = `FIXED_ZERO;
    read_value[`BIT_PARITY_RESPONSE]    = parity_response_enable;
    read_value[`BIT_PALETTE_SNOOP]      = `FIXED_ZERO;
    read_value[`BIT_WRITE_INVALIDATE]   = write_invalidate_enable;
    read_value[`BIT_SPECIAL_CYCLE]      = `FIXED_ZERO;
    read_value[`BIT_BUS_MASTER]         = bus_master_enable;
    read_value[`BIT_MEMORY_SPACE]       = memory_space_enable;
    read_value[`BIT_IO_SPACE]           = io_space_enable;
  end

  // A blocked read in satellite mode returns zero so no state leaks.
  assign rdata_d = rd_hit ? read_value : `RESET_WORD;

  // Bus-side effects of the control bits.
  assign serr_d = system_error_enable & parity_response_enable
                  & (addr_parity_err_i | special_parity_err_i);
  assign perr_d = parity_response_enable & data_parity_err_i;
  assign write_cmd_d = write_invalidate_enable ? `CMD_WRITE_INVALIDATE
                                               : `CMD_MEMORY_WRITE;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `RESET_WORD;
      ack_q   <= 1'h0;
      err_q   <= 1'h0;
    end else begin
      rdata_o <= rdata_d;
      ack_q   <= access_any;
      err_q   <= access_any & satellite_mode_i;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serr_assert_o      <= 1'h0;
      perr_assert_o      <= 1'h0;
      parity_check_o     <= 1'h0;
      fast_b2b_issue_o   <= 1'h0;
      write_cmd_o        <= `CMD_MEMORY_WRITE;
      bus_master_allow_o <= 1'h0;
      mem_claim_o        <= 1'h0;
      io_claim_o         <= 1'h0;
      special_claim_o    <= 1'h0;
    end else begin
      serr_assert_o      <= serr_d;
      perr_assert_o      <= perr_d;
      parity_check_o     <= parity_response_enable;
      fast_b2b_issue_o   <= fast_b2b_enable & bus_master_enable;
      write_cmd_o        <= write_cmd_d;
      bus_master_allow_o <= bus_master_enable;
      mem_claim_o        <= mem_access_i & memory_space_enable;
      io_claim_o         <= io_access_i & io_space_enable;
      special_claim_o    <= special_cycle_i & `FIXED_ZERO;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  parity_flag_set_a: assert property (
    $rose(master_data_parity_flag) |-> $past(perr_seen_i & master_of_failing_i)
                                      && $past(parity_response_enable))
    else $error("Parity flag set without enabled master error.");

  parity_flag_clear_a: assert property (
    (master_data_parity_flag && parity_flag_clear && !parity_flag_set)
      |=> !master_data_parity_flag)
    else $error("Parity flag not cleared by write one.");

  parity_flag_keep_a: assert property (
    (master_data_parity_flag && !parity_flag_clear) |=> master_data_parity_flag)
    else $error("Parity flag lost without a clear.");

  fixed_bits_a: assert property (
    rd_hit |=> rdata_o[23] && rdata_o[21] && rdata_o[20]
               && !rdata_o[7] && !rdata_o[5] && !rdata_o[3])
    else $error("Fixed bits read wrong.");

  reserved_zero_a: assert property (
    ##1 (rdata_o[31:25] == 7'h00 && rdata_o[22] == 1'h0
         && rdata_o[19:10] == 10'h000))
    else $error("Reserved bits not zero.");

  serr_gate_a: assert property (
    serr_assert_o |-> $past(system_error_enable && parity_response_enable))
    else $error("System error without both enables.");

  serr_report_a: assert property (
    (system_error_enable && parity_response_enable && addr_parity_err_i)
      |=> serr_assert_o)
    else $error("Address parity error not reported.");

  parity_ignore_a: assert property (
    !parity_response_enable |=> !perr_assert_o && !serr_assert_o)
    else $error("Parity error answered while response is off.");

  mem_claim_gate_a: assert property (
    mem_claim_o |-> $past(memory_space_enable && mem_access_i))
    else $error("Memory access claimed while disabled.");

  io_claim_gate_a: assert property (
    io_claim_o |-> $past(io_space_enable && io_access_i))
    else $error("I/O access claimed while disabled.");

  bus_master_strap_a: assert property (
    $rose(strap_loaded_q) |-> bus_master_enable == $past(strap_value))
    else $error("Bus master reset value does not follow straps.");

  satellite_block_a: assert property (
    (access_any && satellite_mode_i) |=> err_o && rdata_o == 32'h00000000
                                         && $stable(parity_response_enable))
    else $error("Register reachable in satellite mode.");

  write_cmd_sel_a: assert property (
    write_invalidate_enable |=> write_cmd_o == 4'hF)
    else $error("Write invalidate command not selected.");

  cover_flag_set_c: cover property (parity_flag_set ##1 master_data_parity_flag);
  cover_set_clear_c: cover property (parity_flag_set && parity_flag_clear);
  cover_serr_c: cover property (serr_assert_o);
  cover_satellite_c: cover property (access_any && satellite_mode_i);

endmodule : pci_command_status_bits

// >>> design/pci_cmd_status_consts.svh
// Offsets, field positions, reset values and command codes of the command and status word.
`ifndef PCI_CMD_STATUS_CONSTS_SVH
`define PCI_CMD_STATUS_CONSTS_SVH

`define CSR_OFFSET             16'hD004

`define BIT_MASTER_PARITY      24
`define BIT_FAST_B2B_CAPABLE   23
`define BIT_HIGH_SPEED_CAPABLE 21
`define BIT_CAPABILITIES_LIST  20
`define BIT_FAST_B2B_ENABLE    9
`define BIT_SYSTEM_ERROR_EN    8
`define BIT_STEPPING_CONTROL   7
`define BIT_PARITY_RESPONSE    6
`define BIT_PALETTE_SNOOP      5
`define BIT_WRITE_INVALIDATE   4
`define BIT_SPECIAL_CYCLE      3
`define BIT_BUS_MASTER         2
`define BIT_MEMORY_SPACE       1
`define BIT_IO_SPACE           0

`define FIXED_ONE              1'h1
`define FIXED_ZERO             1'h0
`define RESET_CONTROL          1'h0
`define RESET_FLAG             1'h0
`define RESET_WORD             32'h00000000

`define CMD_MEMORY_WRITE       4'h7
`define CMD_WRITE_INVALIDATE   4'hF

`endif

// >>> design/pci_cmd_status_pkg.sv
// Types shared by the command and status register files.
package pci_cmd_status_pkg;

  typedef logic [31:0] word_type;
  typedef logic [3:0]  pci_cmd_type;
  typedef logic [3:0]  byte_en_type;

endpackage : pci_cmd_status_pkg

// >>> design/sticky_flag.sv
// Sticky event flag with write-one-to-clear, where a set beats a clear.
`include "pci_cmd_status_consts.svh"
module sticky_flag (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_d;

  // A set arriving with the clear must not be lost, so it wins.
  assign flag_d = set_i | (flag_o & ~clear_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= `RESET_FLAG;
    end else begin
      flag_o <= flag_d;
    end
  end

endmodule : sticky_flag

// >>> design/control_field.sv
// Read/write control field with an optional one-shot load that beats a write.
module control_field #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_value_i,
  output logic      [WIDTH-1:0] value_o
);

  logic [WIDTH-1:0] value_d;

  assign value_d = load_i ? load_value_i : (wr_i ? wdata_i : value_o);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      value_o <= '0;
    end else begin
      value_o <= value_d;
    end
  end

endmodule : control_field

// >>> sim/pci_far_side.sv
// Behavioural model of the other initiators and targets on the PCI bus.
module pci_far_side (
  input  wire logic clk_i,
  output logic      perr_seen_o,
  output logic      master_of_failing_o,
  output logic      data_parity_err_o,
  output logic      addr_parity_err_o,
  output logic      special_parity_err_o,
  output logic      mem_access_o,
  output logic      io_access_o,
  output logic      special_cycle_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {special_cycle_o, io_access_o, mem_access_o, special_parity_err_o,
     addr_parity_err_o, data_parity_err_o, master_of_failing_o, perr_seen_o} = 8'h00;
  end

  // Each event lasts one clock, the way a bus phase would, then the lines drop back to idle.
  task automatic raise(input logic [7:0] m);
    @(negedge clk_i);
    {special_cycle_o, io_access_o, mem_access_o, special_parity_err_o,
     addr_parity_err_o, data_parity_err_o, master_of_failing_o, perr_seen_o} = m;
    @(negedge clk_i);
    {special_cycle_o, io_access_o, mem_access_o, special_parity_err_o,
     addr_parity_err_o, data_parity_err_o, master_of_failing_o, perr_seen_o} = 8'h00;
  endtask : raise
endmodule : pci_far_side

// >>> sim/pci_command_status_bits_tb.sv
// Self-checking testbench of the PCI command and status bits.
`include "pci_cmd_status_consts.svh"
`define CHECK_EQ(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module pci_command_status_bits_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  pci_cmd_status_pkg::byte_en_type be_i = 4'h0;
  pci_cmd_status_pkg::word_type wdata_i = 32'h00000000;
  logic satellite_mode_i = 1'b0;
  logic strap_pci_boot_i = 1'b1;
  logic strap_host_mode_i = 1'b1;
  logic perr_seen, master_of_failing, data_parity_err, addr_parity_err;
  logic special_parity_err, mem_access, io_access, special_cycle;
  pci_cmd_status_pkg::word_type rdata_o;
  pci_cmd_status_pkg::pci_cmd_type write_cmd_o;
  logic ack_o, err_o, perr_assert_o, serr_assert_o, parity_check_o;
  logic fast_b2b_issue_o, bus_master_allow_o, mem_claim_o, io_claim_o, special_claim_o;
  int failures = 0;
  int n_checks = 0;

  always #2.5 clk_i = ~clk_i;

  pci_command_status_bits u_pci_command_status_bits (
    .clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .be_i(be_i),
    .wdata_i(wdata_i), .satellite_mode_i(satellite_mode_i),
    .strap_pci_boot_i(strap_pci_boot_i), .strap_host_mode_i(strap_host_mode_i),
    .perr_seen_i(perr_seen), .master_of_failing_i(master_of_failing),
    .data_parity_err_i(data_parity_err), .addr_parity_err_i(addr_parity_err),
    .special_parity_err_i(special_parity_err), .mem_access_i(mem_access),
    .io_access_i(io_access), .special_cycle_i(special_cycle), .rdata_o(rdata_o),
    .ack_o(ack_o), .err_o(err_o), .perr_assert_o(perr_assert_o),
    .serr_assert_o(serr_assert_o), .parity_check_o(parity_check_o),
    .fast_b2b_issue_o(fast_b2b_issue_o), .write_cmd_o(write_cmd_o),
    .bus_master_allow_o(bus_master_allow_o), .mem_claim_o(mem_claim_o),
    .io_claim_o(io_claim_o), .special_claim_o(special_claim_o));

  pci_far_side u_pci_far_side (
    .clk_i(clk_i), .perr_seen_o(perr_seen), .master_of_failing_o(master_of_failing),
    .data_parity_err_o(data_parity_err), .addr_parity_err_o(addr_parity_err),
    .special_parity_err_o(special_parity_err), .mem_access_o(mem_access),
    .io_access_o(io_access), .special_cycle_o(special_cycle));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // The request is held across exactly one rising edge; the answer is judged a cycle later.
  task automatic acc(input logic rd, input logic wr, input logic [15:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic ack, input logic err,
                     input logic [31:0] exp_rd);
    @(negedge clk_i);
    rd_i = rd;
    wr_i = wr;
    addr_i = a;
    be_i = be;
    wdata_i = d;
    @(negedge clk_i);
    rd_i = 1'b0;
    wr_i = 1'b0;
    `CHECK_EQ({ack_o, err_o}, {ack, err})
    `CHECK_EQ(rdata_o, exp_rd)
  endtask : acc

  task automatic wr_ok(input logic [3:0] be, input logic [31:0] d);
    acc(1'b0, 1'b1, `CSR_OFFSET, be, d, 1'b1, 1'b0, 32'h00000000);
  endtask : wr_ok

  task automatic rd_ok(input logic [31:0] exp_rd);
    acc(1'b1, 1'b0, `CSR_OFFSET, 4'h0, 32'h00000000, 1'b1, 1'b0, exp_rd);
  endtask : rd_ok

  // Expected order is perr, serr, memory claim, I/O claim, special claim.
  task automatic ev(input logic [7:0] m, input logic [4:0] exp_out);
    u_pci_far_side.raise(m);
    `CHECK_EQ({perr_assert_o, serr_assert_o, mem_claim_o, io_claim_o, special_claim_o}, exp_out)
  endtask : ev

  // Expected order is parity check, fast issue, bus master, write command.
  // These outputs trail a field write by one more edge, so one edge is let pass first.
  task automatic ctl(input logic [6:0] exp_out);
    @(negedge clk_i);
    `CHECK_EQ({parity_check_o, fast_b2b_issue_o, bus_master_allow_o, write_cmd_o}, exp_out)
  endtask : ctl

  // Two idle edges after release let the straps load before the first request.
  task automatic do_reset(input logic boot, input logic host);
    @(negedge clk_i);
    strap_pci_boot_i = boot;
    strap_host_mode_i = host;
    rst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : do_reset

  task automatic sc_reset_and_fields();
    do_reset(1'b1, 1'b1);
    rd_ok(32'h00B00004);
    ctl(7'h17);
    wr_ok(4'hF, 32'hFFFFFFFF);
    rd_ok(32'h00B00357);
    ctl(7'h7F);
    wr_ok(4'h1, 32'h00000000);
    rd_ok(32'h00B00300);
    ctl(7'h07);
    wr_ok(4'hF, 32'h00000010);
    ctl(7'h0F);
    wr_ok(4'hF, 32'h00000000);
    rd_ok(32'h00B00000);
  endtask : sc_reset_and_fields

  task automatic sc_claims();
    ev(8'hE0, 5'b00000);
    wr_ok(4'h1, 32'h00000003);
    ev(8'hE0, 5'b00110);
    ev(8'h20, 5'b00100);
    ev(8'h80, 5'b00000);
  endtask : sc_claims

  task automatic sc_parity();
    ev(8'h1F, 5'b00000);
    rd_ok(32'h00B00003);
    wr_ok(4'hF, 32'h00000040);
    ev(8'h01, 5'b00000);
    ev(8'h02, 5'b00000);
    rd_ok(32'h00B00040);
    ev(8'h04, 5'b10000);
    ev(8'h18, 5'b00000);
    ev(8'h03, 5'b00000);
    rd_ok(32'h01B00040);
    wr_ok(4'h7, 32'h01000040);
    wr_ok(4'h8, 32'h00000000);
    rd_ok(32'h01B00040);
    wr_ok(4'h8, 32'h01000000);
    rd_ok(32'h00B00040);
    wr_ok(4'hF, 32'h00000100);
    ev(8'h08, 5'b00000);
    wr_ok(4'hF, 32'h00000140);
    ev(8'h08, 5'b01000);
    ev(8'h10, 5'b01000);
    ev(8'h04, 5'b10000);
    // A master error and a write-one clear on the same edge: the set must survive.
    fork
      u_pci_far_side.raise(8'h03);
      wr_ok(4'h8, 32'h01000000);
    join
    rd_ok(32'h01B00140);
    wr_ok(4'h8, 32'h01000000);
    rd_ok(32'h00B00140);
  endtask : sc_parity

  task automatic sc_blocked();
    satellite_mode_i = 1'b1;
    acc(1'b0, 1'b1, `CSR_OFFSET, 4'hF, 32'hFFFFFFFF, 1'b1, 1'b1, 32'h00000000);
    acc(1'b1, 1'b0, `CSR_OFFSET, 4'h0, 32'h00000000, 1'b1, 1'b1, 32'h00000000);
    satellite_mode_i = 1'b0;
    rd_ok(32'h00B00140);
    acc(1'b1, 1'b1, 16'hD008, 4'hF, 32'h00000000, 1'b0, 1'b0, 32'h00000000);
    rd_ok(32'h00B00140);
  endtask : sc_blocked

  task automatic sc_straps();
    do_reset(1'b1, 1'b0);
    rd_ok(32'h00B00000);
    ctl(7'h07);
    do_reset(1'b0, 1'b1);
    ctl(7'h07);
  endtask : sc_straps

  // A hang is cut short here and counted, since every other wait is a fixed count.
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
    final_report();
  end

  initial begin
    sc_reset_and_fields();
    sc_claims();
    sc_parity();
    sc_blocked();
    sc_straps();
    final_report();
  end
endmodule : pci_command_status_bits_tb
